// >>> shared/ampr_consts.svh
`ifndef AMPR_CONSTS_SVH
`define AMPR_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AMPR_CLK_HZ 10000000
`define AMPR_RST_HOLD_US 1000
`define AMPR_RST_HOLD_CYC ((`AMPR_RST_HOLD_US * (`AMPR_CLK_HZ / 1000000)))

// ----------------------------------------------------------------
// Reset values of the controlled settings
// ----------------------------------------------------------------
`define AMPR_SOFT_SHUTDOWN_RST 1'b1
`define AMPR_LIMITER_LOCK_RST 1'b0
`define AMPR_LIMITER_RST 3'h0

`endif

// >>> shared/ampr_pkg.sv
package ampr_pkg;

   typedef enum logic [1:0] {
      AMPR_HELD,
      AMPR_QUALIFY,
      AMPR_RUN
   } ampr_state_t;

   typedef struct packed {
      logic wrEn;
      logic softShutdown;
      logic limiterLock;
      logic lockReq;
      logic [2:0] limiter;
   } ampr_write_t;

   typedef struct packed {
      logic softShutdown;
      logic limiterLock;
      logic [2:0] limiter;
   } ampr_settings_t;

endpackage : ampr_pkg

// >>> design/ampr_sync.sv
`timescale 1ns/1ps

module ampr_sync (
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetPin_n,
   output logic resetSync_n
);
   typedef struct packed {
      logic stage1;
      logic stage2;
   } ampr_sync_state_t;

   ampr_sync_state_t q;
   ampr_sync_state_t next_q;

   // ----------------------------------------------------------------
   // Two-stage synchroniser
   // ----------------------------------------------------------------
   always_comb begin
      next_q.stage1 = resetPin_n;
      next_q.stage2 = q.stage1;
   end

   // Both stages start low so the device counts as held until the pin is seen.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign resetSync_n = q.stage2;
endmodule : ampr_sync

// >>> design/amp_reset_defaults_ctrl.sv
`timescale 1ns/1ps
`include "ampr_consts.svh"


module amp_reset_defaults_ctrl #(
   parameter int unsigned HOLD_CYCLES = `AMPR_RST_HOLD_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetPin_n,
   input ampr_pkg::ampr_write_t wrReq,
   output logic wrAccepted,
   output ampr_pkg::ampr_settings_t settings,
   output logic amplifiersOn,
   output logic inReset
);
   import ampr_pkg::*;

   localparam int CW = $clog2(HOLD_CYCLES + 1);

   typedef struct packed {
      ampr_state_t state;
      logic [CW-1:0] lowCount;
      ampr_settings_t cfg;
      logic amplifiersOn;
   } ampr_ctrl_state_t;

   ampr_ctrl_state_t q;
   ampr_ctrl_state_t next_q;
   logic resetSync_n;
   logic writeOk;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   ampr_sync u_sync (
      .mclk(mclk),
      .rst(rst),
      .resetPin_n(resetPin_n),
      .resetSync_n(resetSync_n)
   );

   // Writes pass only in the run state; during a low pin they are dropped.
   assign writeOk = (q.state == AMPR_RUN) && resetSync_n && wrReq.wrEn;
   assign wrAccepted = writeOk;

   // ----------------------------------------------------------------
   // Control
   // ----------------------------------------------------------------
   always_comb begin
      next_q = q;
      case (q.state)
         AMPR_HELD: begin
            // A qualified reset: defaults are forced for as long as the pin stays low.
            next_q.cfg.softShutdown = `AMPR_SOFT_SHUTDOWN_RST;
            next_q.cfg.limiterLock = `AMPR_LIMITER_LOCK_RST;
            next_q.cfg.limiter = `AMPR_LIMITER_RST;
            next_q.lowCount = '0;
            if (resetSync_n) begin
               next_q.state = AMPR_RUN;
            end
         end
         AMPR_QUALIFY: begin
            // Glitches shorter than the hold time leave settings untouched, a
            // trade-off against reacting to noise on a long reset trace.
            if (!resetSync_n) begin
               if (q.lowCount >= CW'(HOLD_CYCLES - 1)) begin
                  next_q.state = AMPR_HELD;
               end else begin
                  next_q.lowCount = q.lowCount + CW'(1);
               end
            end else begin
               next_q.state = AMPR_RUN;
               next_q.lowCount = '0;
            end
         end
         AMPR_RUN: begin
            if (!resetSync_n) begin
               next_q.state = AMPR_QUALIFY;
               next_q.lowCount = CW'(1);
            end else if (writeOk) begin
               next_q.cfg.softShutdown = wrReq.softShutdown;
               if (wrReq.lockReq) begin
                  next_q.cfg.limiterLock = wrReq.limiterLock;
               end
               // Once locked, the limiter setting holds until a write with lockReq clears the lock, or the next reset.
               if (!q.cfg.limiterLock) begin
                  next_q.cfg.limiter = wrReq.limiter;
               end
            end
         end
         default: begin
            next_q.state = AMPR_HELD;
         end
      endcase
      // Amplifiers run only in the run state with soft shutdown cleared.
      next_q.amplifiersOn = (next_q.state == AMPR_RUN) && resetSync_n
                            && !next_q.cfg.softShutdown;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q.state <= AMPR_HELD;
         q.lowCount <= '0;
         q.cfg.softShutdown <= `AMPR_SOFT_SHUTDOWN_RST;
         q.cfg.limiterLock <= `AMPR_LIMITER_LOCK_RST;
         q.cfg.limiter <= `AMPR_LIMITER_RST;
         q.amplifiersOn <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign settings = q.cfg;
   assign amplifiersOn = q.amplifiersOn;
   assign inReset = (q.state == AMPR_HELD);
endmodule : amp_reset_defaults_ctrl

// >>> tb/ampr_host.sv
`timescale 1ns/1ps

module ampr_host (
   input wire logic mclk,
   input wire logic [7:0] lowLen,
   input wire logic go,
   output logic resetPin_n
);
   // The pin starts low so that the supplies can settle before release.
   logic [7:0] cnt = 8'h14;
   always_ff @(posedge mclk) begin
      if (go) begin
         cnt <= lowLen;
      end else if (cnt != 8'h0) begin
         cnt <= cnt - 8'h1;
      end
   end
   assign resetPin_n = (cnt == 8'h0);
endmodule : ampr_host

// >>> tb/ampr_chk_sva.sv
`timescale 1ns/1ps

module ampr_chk #(
   parameter int unsigned HOLD_CYCLES = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic resetPin_n,
   input wire ampr_pkg::ampr_write_t wrReq,
   input wire logic wrAccepted,
   input wire ampr_pkg::ampr_settings_t settings,
   input wire logic amplifiersOn,
   input wire logic inReset
);
   import ampr_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_defaults_held: assert property (inReset && $past(inReset) |->
      settings == 5'h10 && !amplifiersOn) else $error("defaults not held");
   chk_lock_cleared: assert property ($fell(inReset) |-> !settings.limiterLock)
      else $error("lock not cleared");
   chk_write_refused: assert property (inReset || !$past(resetPin_n, 2) |-> !wrAccepted)
      else $error("write taken in reset");
   chk_wake_shutdown: assert property ($fell(inReset) |-> settings.softShutdown)
      else $error("not in soft shutdown");
   chk_amp_off: assert property (settings.softShutdown || inReset |-> !amplifiersOn)
      else $error("amplifiers on in shutdown");
   chk_write_lands: assert property (wrAccepted |=>
      amplifiersOn == !$past(wrReq.softShutdown)) else $error("write lost");
   chk_pulse_qualify: assert property ($rose(inReset) |->
      !$past(resetPin_n, 3) && !$past(resetPin_n, HOLD_CYCLES)) else $error("short reset");
   cover property ($rose(inReset));
   cover property (wrAccepted);
   cover property ($fell(amplifiersOn) && !inReset);
endmodule : ampr_chk

bind amp_reset_defaults_ctrl ampr_chk #(.HOLD_CYCLES(HOLD_CYCLES)) ampr_chk_inst (.mclk(mclk),
   .rst(rst), .resetPin_n(resetPin_n), .wrReq(wrReq), .wrAccepted(wrAccepted),
   .settings(settings), .amplifiersOn(amplifiersOn), .inReset(inReset));

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
   import ampr_pkg::*;
   logic mclk = 0, rst = 1, go = 0, resetPin_n, wrAccepted, amplifiersOn, inReset;
   logic [7:0] lowLen = 8'h0;
   ampr_write_t wrReq = '0;
   ampr_settings_t settings;
   int n_fail = 0, n_compared = 0, cyc = 0;
   always #50 mclk = ~mclk;
   amp_reset_defaults_ctrl #(.HOLD_CYCLES(8)) amp_reset_defaults_ctrl_inst (.mclk(mclk),
      .rst(rst), .resetPin_n(resetPin_n), .wrReq(wrReq), .wrAccepted(wrAccepted),
      .settings(settings), .amplifiersOn(amplifiersOn), .inReset(inReset));
   ampr_host ampr_host_inst (.mclk(mclk), .lowLen(lowLen), .go(go), .resetPin_n(resetPin_n));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk
   task step(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask : step
   task wr(input ampr_write_t w, input logic acc);
      wrReq = w;
      #1;
      chk(wrAccepted === acc, "write acceptance");
      step(1);
      wrReq = '0;
   endtask : wr
   task pulse(input logic [7:0] n);
      lowLen = n;
      go = 1'b1;
      step(1);
      go = 1'b0;
   endtask : pulse
   task wait_release;
      for (int i = 0; i < 60 && inReset !== 1'b0; i++) step(1);
      step(1);
      chk(settings === 5'h10 && amplifiersOn === 1'b0, "start-up state");
   endtask : wait_release
   task end_of_test;
      $display("compared %0d n_fail %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         end_of_test();
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      step(10);
      rst = 1'b0;
      wait_release();
      wr('{1'b1, 1'b0, 1'b1, 1'b1, 3'h5}, 1'b1);
      chk(settings === 5'h0d && amplifiersOn === 1'b1, "write wake");
      wr('{1'b1, 1'b1, 1'b1, 1'b0, 3'h2}, 1'b1);
      chk(settings.limiter === 3'h5 && amplifiersOn === 1'b0, "lock or shutdown");
      wr('{1'b1, 1'b0, 1'b1, 1'b0, 3'h5}, 1'b1);
      pulse(8'h3);
      step(2);
      wr('{1'b1, 1'b0, 1'b0, 1'b1, 3'h1}, 1'b0);
      chk(amplifiersOn === 1'b0, "amplifiers on while pin low");
      step(6);
      chk(settings === 5'h0d && inReset === 1'b0 && amplifiersOn === 1'b1, "short pulse");
      pulse(8'h0e);
      step(12);
      chk(inReset === 1'b1 && settings === 5'h10, "qualified reset");
      wr('{1'b1, 1'b0, 1'b0, 1'b0, 3'h3}, 1'b0);
      wait_release();
      wr('{1'b1, 1'b0, 1'b0, 1'b0, 3'h6}, 1'b1);
      chk(settings.limiter === 3'h6, "limiter writable");
      end_of_test();
   end
endmodule : tb
